// ### verilog/shrp_pkg.sv
/*
  shrp_pkg: constants shared by the serial host register port.
  Assumes nothing of its surroundings; imported whole by the port module.
*/
package shrp_pkg;

  // command word layout, bit 15 shifted first
  localparam int CMD_DIR_BIT    = 15;  // 1 = read
  localparam int CMD_EVERY_BIT  = 14;  // write_everyone_bit
  localparam int CMD_EXTMEM_BIT = 13;  // external_memory_bit, not used here
  localparam int CMD_STEP_BIT   = 12;  // burst_step_bit
  localparam int CMD_ID_MSB     = 11;
  localparam int CMD_ID_LSB     = 7;
  localparam int CMD_ADDR_MSB   = 6;
  localparam int CMD_ADDR_LSB   = 0;

  // word geometry
  localparam int          WORD_W    = 16;
  localparam logic [3:0]  LAST_BIT  = 4'hf;  // count of the final bit of a word
  localparam int          ID_W      = 5;
  localparam int          ADDR_W    = 7;

  // host-port configuration register
  localparam logic [6:0]  HOST_PORT_CONFIG_OFS = 7'h00;
  localparam logic [15:0] HOST_PORT_CONFIG_RST = 16'h0000;
  localparam int          CFG_ID_LSB           = 0;   // chain id, bits 4:0
  localparam int          CFG_PASSOFF_BIT      = 5;   // passthrough_off_bit
  localparam int          CFG_SHARED_BIT       = 6;   // shared_output_enable_bit
  localparam logic [15:0] CFG_WRITE_MASK       = 16'h007f;

  // pin levels held by the output flops during reset
  localparam logic        SERIAL_OUT_LINE_RST    = 1'b1;
  localparam logic        SERIAL_OUT_LINE_OE_RST = 1'b1;

  // host timing, in shift-clock periods (host keeps these)
  localparam int READ_TURNAROUND_GAP  = 4;
  localparam int WRITE_TURNAROUND_GAP = 1;
  localparam int COMMAND_GAP          = 3;
  localparam int CONFIG_COMMAND_GAP   = 4;

  // access sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } shrp_state_t;

endpackage

// ### verilog/shrp_port.sv
/*
  shrp_port: slave end of the four-wire serial host register port, with its
  register store, chain id and loop-through output.
  Assumes the shift clock, select and serial input arrive from pins unrelated
  to clk_i and run at least eight times slower than clk_i.
*/
// Overview of operation
// - sample serial input on shift clock rise
// - change read output on shift clock fall
// - ignore shift clock while select is high
// - access opens on select fall, 32+ bits
// - first 16 bits after select fall: command
// - bit 15 chooses read or write
// - write_everyone_bit set: write ignoring chain id
// - write_everyone_bit clear: write needs id match
// - burst_step_bit set: address steps per word
// - burst_step_bit clear: exactly one data word
// - accept only when chain id field matches, or on a write with write_everyone_bit set
// - chain id is zero after reset
// - bits 6:0 give register or start address
// - four idle periods before read data
// - loop input to output except during reads
// - passthrough_off_bit holds output high except during reads
// - shared_output_enable_bit floats output when deselected
`timescale 1ns/10ps
module shrp_port
  import shrp_pkg::*;
#(
  parameter int REG_COUNT = 128
) (
  // clock, reset, enable
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  // serial pins from the host
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic serial_in_line_i,
  // serial output pin, split into level and enable
  output logic      serial_out_line_o,
  output logic      serial_out_line_oe_o
);

  // two-flop synchronisers plus a third stage for edge finding
  logic [2:0] sclk_sy_r, sclk_sy_nxt;
  logic [2:0] cs_sy_r,   cs_sy_nxt;
  logic [1:0] din_sy_r,  din_sy_nxt;

  always_comb begin
    sclk_sy_nxt = {sclk_sy_r[1:0], sclk_i};
    cs_sy_nxt   = {cs_sy_r[1:0], cs_n_i};
    din_sy_nxt  = {din_sy_r[0], serial_in_line_i};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_sy_r <= 3'h0;
      cs_sy_r   <= 3'h7;
      din_sy_r  <= 2'h3;
    end else if (en_i) begin
      sclk_sy_r <= sclk_sy_nxt;
      cs_sy_r   <= cs_sy_nxt;
      din_sy_r  <= din_sy_nxt;
    end
  end

  // only second and third stages are looked at
  logic sclk_rise;
  logic sclk_fall;
  logic cs_high;
  logic cs_fall;
  logic din;
  assign sclk_rise = sclk_sy_r[1] & ~sclk_sy_r[2];
  assign sclk_fall = ~sclk_sy_r[1] & sclk_sy_r[2];
  assign cs_high   = cs_sy_r[1];
  assign cs_fall   = ~cs_sy_r[1] & cs_sy_r[2];
  assign din       = din_sy_r[1];

  // register store; word 0 is the host-port configuration held apart
  logic [WORD_W-1:0] regs [REG_COUNT];
  logic [WORD_W-1:0] host_port_config_r, host_port_config_nxt;

  // access sequencer state
  shrp_state_t       state_r,  state_nxt;
  logic [3:0]        cnt_r,    cnt_nxt;
  logic [WORD_W-1:0] sh_in_r,  sh_in_nxt;
  logic [WORD_W-1:0] sh_out_r, sh_out_nxt;
  logic [WORD_W-1:0] cmd_r,    cmd_nxt;
  logic [ADDR_W-1:0] addr_r,   addr_nxt;
  logic              rd_bit_r, rd_bit_nxt;
  logic              serial_out_line_r,  serial_out_line_nxt;
  logic              sdoe_r,   sdoe_nxt;
  logic              mem_we;
  logic [WORD_W-1:0] mem_wdata;

  // fetch a word for the read path
  function automatic logic [WORD_W-1:0] fetch(input logic [ADDR_W-1:0] a,
                                              input logic [WORD_W-1:0] cfg);
    if (a == HOST_PORT_CONFIG_OFS) begin
      fetch = cfg;
    end else if (32'(a) < REG_COUNT) begin
      fetch = regs[a];
    end else begin
      fetch = '0;
    end
  endfunction

  // chain id compare for the current command
  logic id_match;
  logic rd_access;
  assign id_match  = cmd_r[CMD_ID_MSB:CMD_ID_LSB] ==
                     host_port_config_r[CFG_ID_LSB +: ID_W];
  assign rd_access = (state_r == ST_DATA) && cmd_r[CMD_DIR_BIT] && id_match;

  // sequencer next state; the select level overrides all shift activity
  always_comb begin
    logic [WORD_W-1:0] word;
    word                 = {sh_in_r[WORD_W-2:0], din};
    state_nxt            = state_r;
    cnt_nxt              = cnt_r;
    sh_in_nxt            = sh_in_r;
    sh_out_nxt           = sh_out_r;
    cmd_nxt              = cmd_r;
    addr_nxt             = addr_r;
    rd_bit_nxt           = rd_bit_r;
    host_port_config_nxt = host_port_config_r;
    mem_we               = 1'b0;
    mem_wdata            = word;
    if (cs_high) begin
      state_nxt = ST_IDLE;
    end else if (cs_fall) begin
      state_nxt = ST_CMD;
      cnt_nxt   = 4'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            sh_in_nxt = word;
            cnt_nxt   = cnt_r + 4'h1;
            if (cnt_r == LAST_BIT) begin
              cmd_nxt    = word;
              addr_nxt   = word[CMD_ADDR_MSB:CMD_ADDR_LSB];
              state_nxt  = ST_DATA;
              // prepared on the rise of the last command bit, before the read turnaround gap
              // nothing is shifted yet: the fall that closes this bit puts out bit 15,
              // otherwise that fall would push bit 15 out before the host saw it
              sh_out_nxt = fetch(word[CMD_ADDR_MSB:CMD_ADDR_LSB], host_port_config_r);
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            sh_in_nxt = word;
            cnt_nxt   = cnt_r + 4'h1;
            if (cnt_r == LAST_BIT) begin
              // write accepted on a broadcast or an id match
              if (!cmd_r[CMD_DIR_BIT] && (cmd_r[CMD_EVERY_BIT] || id_match)) begin
                if (addr_r == HOST_PORT_CONFIG_OFS) begin
                  host_port_config_nxt = word & CFG_WRITE_MASK;
                end else begin
                  mem_we = 1'b1;
                end
              end
              if (cmd_r[CMD_STEP_BIT]) begin
                addr_nxt   = addr_r + 7'h01;
                sh_out_nxt = fetch(addr_nxt, host_port_config_r);
              end else begin
                state_nxt = ST_DONE;
              end
            end
          end else if (sclk_fall && rd_access) begin
            rd_bit_nxt = sh_out_r[WORD_W-1];
            sh_out_nxt = {sh_out_r[WORD_W-2:0], 1'b0};
          end
        end
        ST_DONE: begin
          state_nxt = ST_DONE; // further words are ignored until select rises
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // output pin: registered, so the loop-through adds a few clk_i of delay
  always_comb begin
    if (rd_access) begin
      serial_out_line_nxt = rd_bit_r;
    end else if (host_port_config_r[CFG_PASSOFF_BIT]) begin
      serial_out_line_nxt = 1'b1;
    end else begin
      serial_out_line_nxt = din;
    end
    sdoe_nxt = host_port_config_r[CFG_SHARED_BIT] ? ~cs_high : 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r            <= ST_IDLE;
      cnt_r              <= 4'h0;
      sh_in_r            <= '0;
      sh_out_r           <= '0;
      cmd_r              <= '0;
      addr_r             <= '0;
      rd_bit_r           <= SERIAL_OUT_LINE_RST;
      host_port_config_r <= HOST_PORT_CONFIG_RST;
      serial_out_line_r            <= SERIAL_OUT_LINE_RST;
      sdoe_r             <= SERIAL_OUT_LINE_OE_RST;
    end else if (en_i) begin
      state_r            <= state_nxt;
      cnt_r              <= cnt_nxt;
      sh_in_r            <= sh_in_nxt;
      sh_out_r           <= sh_out_nxt;
      cmd_r              <= cmd_nxt;
      addr_r             <= addr_nxt;
      rd_bit_r           <= rd_bit_nxt;
      host_port_config_r <= host_port_config_nxt;
      serial_out_line_r            <= serial_out_line_nxt;
      sdoe_r             <= sdoe_nxt;
    end
  end

  // store has no reset; its contents are outside this block's concern
  always_ff @(posedge clk_i) begin
    if (en_i && mem_we && 32'(addr_r) < REG_COUNT) begin
      regs[addr_r] <= mem_wdata;
    end
  end

  assign serial_out_line_o    = serial_out_line_r;
  assign serial_out_line_oe_o = sdoe_r;

endmodule // shrp_port

// ### tb/shrp_port_assertions.sv
/*
  Pin checker for shrp_port, bound to every instance.
  Assumes en_i held high and a shift clock at least eight clk_i periods long.
*/
`timescale 1ns/10ps
module shrp_port_assertions (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_line_i,
  input wire logic serial_out_line_o,
  input wire logic serial_out_line_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] quiet_r;  // cycles since any input pin moved, saturating
  // the synchronisers delay every effect, so a cause may lie a few cycles back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) quiet_r <= 3'h0;
    else if ($changed(sclk_i) || $changed(cs_n_i) || $changed(serial_in_line_i)) quiet_r <= 3'h0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  end
  AST_DESEL_OUT: assert property ((cs_n_i && $stable(serial_in_line_i))[*6] |=> $stable(serial_out_line_o))
    else $error("output moved while deselected");
  AST_DESEL_OE: assert property ((cs_n_i && $stable(serial_in_line_i))[*6] |=>
    $stable(serial_out_line_oe_o))
    else $error("enable moved while deselected");
  AST_LOOP_LEVEL: assert property ((cs_n_i && $stable(serial_in_line_i))[*6] |=>
    (serial_out_line_o == serial_in_line_i || serial_out_line_o || !serial_out_line_oe_o))
    else $error("output neither loops input nor sits high");
  AST_OE_SEL: assert property ((!cs_n_i)[*6] |-> serial_out_line_oe_o)
    else $error("output floats while selected");
  AST_OE_FALL: assert property ($fell(serial_out_line_oe_o) |-> $past(cs_n_i, 1) && $past(cs_n_i, 2))
    else $error("output released without select high");
  AST_OE_RISE: assert property ($rose(serial_out_line_oe_o) |-> !$past(cs_n_i, 1) && !$past(cs_n_i, 2))
    else $error("output driven without select low");
  AST_OUT_CAUSED: assert property ($changed(serial_out_line_o) |-> quiet_r < 3'h6)
    else $error("output moved with no pin activity");
  AST_SEL_HOLD: assert property ((!cs_n_i && $stable(sclk_i) && $stable(serial_in_line_i))[*8]
    |-> $stable(serial_out_line_o))
    else $error("output moved without a shift clock edge");
endmodule // shrp_port_assertions
bind shrp_port shrp_port_assertions u_shrp_port_assertions (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .serial_in_line_i(serial_in_line_i),
  .serial_out_line_o(serial_out_line_o), .serial_out_line_oe_o(serial_out_line_oe_o));

// ### tb/shrp_host_model.sv
/*
  Host model for the serial register port: makes shift clock, select and data.
  Assumes clk_i is the 100 ns system clock; a single device on the select.
*/
`timescale 1ns/10ps
module shrp_host_model (
  // system clock for pacing
  input  wire logic clk_i,
  // serial pins
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // 500 ns low then 300 ns high: 1.25 MHz, one device only
  task automatic word(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      sdi_o = tx[i];  // msb first
      tick(5);
      sclk_o = 1'b1;
      rx[i] = sdo_i;  // device output taken at the rise
      tick(3);
      sclk_o = 1'b0;
    end
  endtask
  // command, idle gap, data words; read gap 4 periods, write gap 1
  task automatic acc(input logic [15:0] cmd, input int n, input logic [15:0] wd [4], output logic [15:0] rd [4]);
    logic [15:0] junk;
    cs_n_o = 1'b0;
    tick(3);
    word(cmd, junk);
    sdi_o = ~sdi_o;
    tick(cmd[15] ? 32 : 8);
    for (int k = 0; k < n; k++) word(wd[k], rd[k]);
    tick(2);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;  // stale level never lingers
    tick(32);        // long enough after a config write too
  endtask
  // shift clock and data wiggle with select high
  task automatic noise();
    for (int i = 0; i < 8; i++) begin
      sdi_o = i[0];
      sclk_o = ~sclk_o;
      tick(4);
    end
  endtask
endmodule // shrp_host_model

// ### tb/testbench.sv
/*
  Testbench for shrp_port: host model accesses, read-back compared.
  Assumes package, design, checker and host model compiled first.
*/
`timescale 1ns/10ps
module testbench;
  import shrp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        sclk, cs_n, sdi, sdo, sdo_oe;
  logic [15:0] wd [4];
  logic [15:0] rd [4];
  int          err_count = 0;
  int          total_checks = 0;
  always #50 clk_i = ~clk_i;
  shrp_port u_shrp_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_in_line_i(sdi), .serial_out_line_o(sdo), .serial_out_line_oe_o(sdo_oe));
  // a released output reads back inverted, so a missing drive cannot pass unseen
  logic        sdo_seen;
  assign sdo_seen = sdo_oe ? sdo : ~sdo;
  shrp_host_model u_shrp_host_model (.clk_i(clk_i), .sdo_i(sdo_seen), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
  // reads keep bit 14 clear, bit 13 always clear
  function automatic logic [15:0] cmd(logic r, logic b, logic s, logic [4:0] id, logic [6:0] a);
    return {r, b, 1'b0, s, id, a};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] c, input int n, input logic [15:0] d0, d1, d2);
    wd = '{d0, d1, d2, 16'h0};
    u_shrp_host_model.acc(c, n, wd, rd);
  endtask
  // filler on the input shows up if the device fails to drive
  task automatic rdk(input logic [15:0] c, input logic [15:0] e0, e1, e2);
    wd = '{4{16'h5a5a}};
    u_shrp_host_model.acc(c, c[12] ? 3 : 1, wd, rd);
    chk(rd[0], e0);
    if (c[12]) begin
      chk(rd[1], e1);
      chk(rd[2], e2);
    end
  endtask
  // watchdog against a hung run
  initial begin
    #2_000_000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    u_shrp_host_model.tick(4);
    rdk(cmd(1'b1, 1'b0, 1'b0, 5'h00, 7'h00), HOST_PORT_CONFIG_RST, 16'h0, 16'h0);
    wr(cmd(1'b0, 1'b0, 1'b1, 5'h00, 7'h10), 3, 16'h8001, 16'h4002, 16'h2003);
    rdk(cmd(1'b1, 1'b0, 1'b1, 5'h00, 7'h10), 16'h8001, 16'h4002, 16'h2003);
    wr(cmd(1'b0, 1'b0, 1'b0, 5'h00, 7'h11), 1, 16'h1234, 16'h0, 16'h0);
    rdk(cmd(1'b1, 1'b0, 1'b1, 5'h00, 7'h10), 16'h8001, 16'h1234, 16'h2003);
    wr(cmd(1'b0, 1'b0, 1'b0, 5'h05, 7'h12), 1, 16'h7777, 16'h0, 16'h0);
    wr(cmd(1'b0, 1'b1, 1'b0, 5'h09, 7'h10), 1, 16'h0bcd, 16'h0, 16'h0);
    rdk(cmd(1'b1, 1'b0, 1'b1, 5'h00, 7'h10), 16'h0bcd, 16'h1234, 16'h2003);
    wr(cmd(1'b0, 1'b0, 1'b0, 5'h00, 7'h00), 1, 16'h0003, 16'h0, 16'h0);
    rdk(cmd(1'b1, 1'b0, 1'b0, 5'h00, 7'h10), 16'h5a5a, 16'h0, 16'h0);
    rdk(cmd(1'b1, 1'b0, 1'b0, 5'h03, 7'h00), 16'h0003, 16'h0, 16'h0);
    wr(cmd(1'b0, 1'b0, 1'b0, 5'h03, 7'h00), 1, 16'h0023, 16'h0, 16'h0);
    rdk(cmd(1'b1, 1'b0, 1'b0, 5'h00, 7'h10), 16'hffff, 16'h0, 16'h0);
    u_shrp_host_model.noise();
    rdk(cmd(1'b1, 1'b0, 1'b0, 5'h03, 7'h10), 16'h0bcd, 16'h0, 16'h0);
    chk({15'h0, sdo_oe}, 16'h0001);
    wr(cmd(1'b0, 1'b0, 1'b0, 5'h03, 7'h00), 1, 16'h0043, 16'h0, 16'h0);
    chk({15'h0, sdo_oe}, 16'h0000);
    rdk(cmd(1'b1, 1'b0, 1'b0, 5'h03, 7'h00), 16'h0043, 16'h0, 16'h0);
    summarize();
  end
endmodule // testbench
